/* pkg/sbap_params.svh */
// Offsets, field positions, reset values and timing counts of the serial byte access port
`ifndef SBAP_PARAMS_SVH
`define SBAP_PARAMS_SVH

`define SBAP_OFS_DATA 8'hb0
`define SBAP_OFS_INDEX 8'hb1
`define SBAP_OFS_TARGET 8'hb2
`define SBAP_OFS_CTRL 8'hb3

`define SBAP_CTL_SHORT 7
`define SBAP_CTL_BUSY 5
`define SBAP_CTL_TEST 2
`define SBAP_CTL_ERR 1
`define SBAP_DIR_BIT 0

`define SBAP_RST_BYTE 8'h00

`define SBAP_CLK_NS 5
`define SBAP_SCL_NORM_NS 10000
`define SBAP_SCL_TEST_NS 2500
`define SBAP_QTR_NORM ((`SBAP_SCL_NORM_NS) / (4 * `SBAP_CLK_NS))
`define SBAP_QTR_TEST ((`SBAP_SCL_TEST_NS) / (4 * `SBAP_CLK_NS))

`endif

/* pkg/sbap_pkg.sv */
// Types shared by the serial byte access port modules
package sbap_pkg;
  typedef enum logic [1:0] {CMD_START, CMD_RSTART, CMD_STOP, CMD_BIT} sbap_bit_cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_SEND, ST_SACK, ST_RSTART, ST_RECV, ST_MACK, ST_STOP
  } sbap_state_t;
  typedef enum logic [1:0] {STEP_ADDR, STEP_INDEX, STEP_RADDR, STEP_DATA} sbap_step_t;
endpackage

/* pkg/sbap_bit_if.sv */
// Link between the byte sequencer and the bit engine
`timescale 1ns/1ps
interface sbap_bit_if;
  logic cmd_valid;
  sbap_pkg::sbap_bit_cmd_t cmd;
  logic din;
  logic fast;
  logic scl_lvl;
  logic sda_lvl;
  logic done;
  logic dout;
  modport ctl (output cmd_valid, output cmd, output din, output fast, output scl_lvl,
    output sda_lvl, input done, input dout);
  modport eng (input cmd_valid, input cmd, input din, input fast, input scl_lvl,
    input sda_lvl, output done, output dout);
endinterface

/* design/sbap_bit_engine.sv */
// Bit engine: start, repeated start, stop and single bit slots on the two-wire bus
`timescale 1ns/1ps
`include "sbap_params.svh"
module sbap_bit_engine #(
  parameter int CW = 12,
  parameter int QTR_NORM = `SBAP_QTR_NORM,
  parameter int QTR_TEST = `SBAP_QTR_TEST
) (
  input wire logic clock,
  input wire logic rst_n,
  sbap_bit_if.eng bus,
  output logic scl_oe,
  output logic sda_oe
);
  logic active_r;
  sbap_pkg::sbap_bit_cmd_t cmd_r;
  logic din_r;
  logic [1:0] phase_r;
  logic [CW-1:0] cnt_r;
  logic dout_r;
  logic done_r;
  logic scl_oe_r;
  logic sda_oe_r;

  // Each slot is four quarter periods; these say which quarters release SCL or pull SDA
  wire is_start = (cmd_r == sbap_pkg::CMD_START);
  wire is_rstart = (cmd_r == sbap_pkg::CMD_RSTART);
  wire is_stop = (cmd_r == sbap_pkg::CMD_STOP);
  wire scl_rel = is_start ? (phase_r != 2'd3) :
                 is_stop ? (phase_r != 2'd0) :
                 (phase_r == 2'd1 || phase_r == 2'd2);
  wire sda_low = is_start ? (phase_r != 2'd0) :
                 is_rstart ? phase_r[1] :
                 is_stop ? !phase_r[1] : !din_r;
  // A target holding SCL low stretches the quarter
  wire stretch = active_r && scl_rel && !bus.scl_lvl;
  wire [CW-1:0] limit = bus.fast ? CW'(QTR_TEST - 1) : CW'(QTR_NORM - 1); // R12
  wire quarter_end = active_r && !stretch && (cnt_r == limit);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      active_r <= 1'b0;
      cmd_r <= sbap_pkg::CMD_STOP;
      din_r <= 1'b1;
      phase_r <= 2'd0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end
    else if (!active_r)
    begin
      done_r <= 1'b0;
      if (bus.cmd_valid)
      begin
        active_r <= 1'b1;
        cmd_r <= bus.cmd;
        din_r <= bus.din;
        phase_r <= 2'd0;
        cnt_r <= '0;
      end
    end
    else if (quarter_end)
    begin
      cnt_r <= '0;
      phase_r <= phase_r + 2'd1;
      if (phase_r == 2'd3)
      begin
        active_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
    else if (!stretch)
    begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  // SDA is sampled at the end of the high half of the bit slot
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dout_r <= 1'b1;
    else if (quarter_end && phase_r == 2'd2 && cmd_r == sbap_pkg::CMD_BIT)
      dout_r <= bus.sda_lvl;
  end

  // Pins keep their last level between slots
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (active_r)
    begin
      scl_oe_r <= !scl_rel;
      sda_oe_r <= sda_low;
    end
  end

  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;
  assign bus.done = done_r;
  assign bus.dout = dout_r;
endmodule

/* design/sbap_top.sv */
// Serial byte access port: software-requested single byte reads and writes on the two-wire bus
// Operation
// R1: Software writes the data byte, then the byte address, then the target address with direction zero to ask for a write.
// R2: Software writes the byte address, then the target address with direction one, then polls busy before taking the data.
// R3: The data register is 8 bits read/write, holds the byte to send or the byte received, and resets to zero.
// R4: The index register is 8 bits read/write and is sent as the byte address in each indexed access.
// R5: The upper seven bits of the address register are sent as the target address.
// R6: Bit zero of the address register is the direction, zero for write and one for read.
// R7: A received byte lands in the data register before busy drops.
// R8: Data, index and target registers clear only on the global reset.
// R9: Writing the target address register starts the access and sets busy until it finishes.
// R10: A missing acknowledge sets a sticky error flag that a written one clears.
// R11: With the short protocol bit set, writes use send-byte and reads receive-byte with no index byte.
// R12: The serial clock runs near 100 kHz, faster when the test bit is set.
// R13: An indexed read sends address with write direction and index, repeated start, address with read direction, one byte, not-acknowledge and stop.
`timescale 1ns/1ps
`include "sbap_params.svh"
module sbap_top #(
  parameter int CW = 12,
  parameter int QTR_NORM = `SBAP_QTR_NORM,
  parameter int QTR_TEST = `SBAP_QTR_TEST
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  logic [1:0] rst_s_r;
  logic rst_n;
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_f_r;
  logic sda_f_r;
  logic [7:0] data_r;
  logic [7:0] index_r;
  logic [7:0] target_r;
  logic short_r;
  logic test_r;
  logic err_r;
  logic busy_r;
  logic [7:0] rdata_r;
  sbap_pkg::sbap_state_t state_r;
  sbap_pkg::sbap_state_t state_nxt;
  sbap_pkg::sbap_step_t step_r;
  sbap_pkg::sbap_step_t step_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic wait_r;
  logic wait_nxt;
  logic busy_nxt;
  logic err_set;
  logic load_rd;

  sbap_bit_if bif ();

  // Global reset: asserted at once, released through two flops
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rst_s_r <= 2'b00;
    else
      rst_s_r <= {rst_s_r[0], 1'b1};
  end
  assign rst_n = rst_s_r[1];

  // Bus lines pass three flops; a new level counts once the last two agree
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_s_r <= 3'b111;
      sda_s_r <= 3'b111;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end
    else
    begin
      scl_s_r <= {scl_s_r[1:0], scl_in};
      sda_s_r <= {sda_s_r[1:0], sda_in};
      if (scl_s_r[1] == scl_s_r[2])
        scl_f_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2])
        sda_f_r <= sda_s_r[2];
    end
  end

  // Register decode; software writes to the byte registers are ignored while an access runs
  wire hit_data = cfg_wr && (cfg_addr == `SBAP_OFS_DATA) && !busy_r;
  wire hit_index = cfg_wr && (cfg_addr == `SBAP_OFS_INDEX) && !busy_r;
  wire hit_target = cfg_wr && (cfg_addr == `SBAP_OFS_TARGET) && !busy_r;
  wire hit_ctrl = cfg_wr && (cfg_addr == `SBAP_OFS_CTRL);
  wire err_clr = hit_ctrl && cfg_wdata[`SBAP_CTL_ERR];
  wire dir_rd = target_r[`SBAP_DIR_BIT]; // R6
  wire [7:0] ctrl_view = {short_r, 1'b0, busy_r, 2'b00, test_r, err_r, 1'b0};
  wire [7:0] rd_mux = (cfg_addr == `SBAP_OFS_DATA) ? data_r :
                      (cfg_addr == `SBAP_OFS_INDEX) ? index_r :
                      (cfg_addr == `SBAP_OFS_TARGET) ? target_r :
                      (cfg_addr == `SBAP_OFS_CTRL) ? ctrl_view : 8'h00;
  // First address byte carries the read direction only for a receive-byte read
  wire [7:0] first_addr = {cfg_wdata[7:1], short_r & cfg_wdata[`SBAP_DIR_BIT]}; // R5 R11 R13

  assign bif.cmd_valid = (state_r != sbap_pkg::ST_IDLE) && !wait_r;
  assign bif.cmd = (state_r == sbap_pkg::ST_START) ? sbap_pkg::CMD_START :
                   (state_r == sbap_pkg::ST_RSTART) ? sbap_pkg::CMD_RSTART :
                   (state_r == sbap_pkg::ST_STOP) ? sbap_pkg::CMD_STOP : sbap_pkg::CMD_BIT;
  // Acknowledge slots release SDA; the final received byte is not acknowledged
  assign bif.din = (state_r == sbap_pkg::ST_SEND) ? shift_r[7] : 1'b1; // R13
  assign bif.fast = test_r; // R12
  assign bif.scl_lvl = scl_f_r;
  assign bif.sda_lvl = sda_f_r;

  always_comb
  begin
    state_nxt = state_r;
    step_nxt = step_r;
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    wait_nxt = wait_r;
    busy_nxt = busy_r;
    err_set = 1'b0;
    load_rd = 1'b0;
    if (bif.cmd_valid)
      wait_nxt = 1'b1;
    if (state_r == sbap_pkg::ST_IDLE)
    begin
      if (hit_target)
      begin
        state_nxt = sbap_pkg::ST_START; // R9
        busy_nxt = 1'b1; // R9
        step_nxt = sbap_pkg::STEP_ADDR;
        shift_nxt = first_addr;
        bit_nxt = 3'd7;
      end
    end
    else if (bif.done)
    begin
      wait_nxt = 1'b0;
      unique case (state_r)
        sbap_pkg::ST_START:
          state_nxt = sbap_pkg::ST_SEND;
        sbap_pkg::ST_SEND:
        begin
          shift_nxt = {shift_r[6:0], 1'b0};
          bit_nxt = bit_r - 3'd1;
          if (bit_r == 3'd0)
            state_nxt = sbap_pkg::ST_SACK;
        end
        sbap_pkg::ST_SACK:
        begin
          bit_nxt = 3'd7;
          if (bif.dout)
          begin
            err_set = 1'b1; // R10
            state_nxt = sbap_pkg::ST_STOP;
          end
          else
          begin
            unique case (step_r)
              sbap_pkg::STEP_ADDR:
              begin
                if (short_r && dir_rd)
                  state_nxt = sbap_pkg::ST_RECV; // R11
                else if (short_r)
                begin
                  state_nxt = sbap_pkg::ST_SEND; // R11
                  step_nxt = sbap_pkg::STEP_DATA;
                  shift_nxt = data_r; // R3
                end
                else
                begin
                  state_nxt = sbap_pkg::ST_SEND;
                  step_nxt = sbap_pkg::STEP_INDEX;
                  shift_nxt = index_r; // R4
                end
              end
              sbap_pkg::STEP_INDEX:
              begin
                if (dir_rd)
                  state_nxt = sbap_pkg::ST_RSTART; // R13
                else
                begin
                  state_nxt = sbap_pkg::ST_SEND;
                  step_nxt = sbap_pkg::STEP_DATA;
                  shift_nxt = data_r; // R3
                end
              end
              sbap_pkg::STEP_RADDR:
                state_nxt = sbap_pkg::ST_RECV; // R13
              sbap_pkg::STEP_DATA:
                state_nxt = sbap_pkg::ST_STOP;
            endcase
          end
        end
        sbap_pkg::ST_RSTART:
        begin
          state_nxt = sbap_pkg::ST_SEND;
          step_nxt = sbap_pkg::STEP_RADDR;
          shift_nxt = {target_r[7:1], 1'b1}; // R5 R13
        end
        sbap_pkg::ST_RECV:
        begin
          shift_nxt = {shift_r[6:0], bif.dout};
          bit_nxt = bit_r - 3'd1;
          if (bit_r == 3'd0)
            state_nxt = sbap_pkg::ST_MACK;
        end
        sbap_pkg::ST_MACK:
        begin
          load_rd = 1'b1; // R7
          state_nxt = sbap_pkg::ST_STOP;
        end
        sbap_pkg::ST_STOP:
        begin
          busy_nxt = 1'b0; // R9
          state_nxt = sbap_pkg::ST_IDLE;
        end
        default:
          state_nxt = sbap_pkg::ST_IDLE;
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= sbap_pkg::ST_IDLE;
      step_r <= sbap_pkg::STEP_ADDR;
      shift_r <= `SBAP_RST_BYTE;
      bit_r <= 3'd7;
      wait_r <= 1'b0;
      busy_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      step_r <= step_nxt;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      wait_r <= wait_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Software registers, cleared by the global reset alone
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_r <= `SBAP_RST_BYTE; // R3 R8
      index_r <= `SBAP_RST_BYTE; // R8
      target_r <= `SBAP_RST_BYTE; // R8
    end
    else
    begin
      if (load_rd)
        data_r <= shift_r; // R7
      else if (hit_data)
        data_r <= cfg_wdata; // R3
      if (hit_index)
        index_r <= cfg_wdata; // R4
      if (hit_target)
        target_r <= cfg_wdata; // R5 R6
    end
  end

  // Control bits; an error raised in the cycle of a clear is kept
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      short_r <= 1'b0;
      test_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      if (hit_ctrl)
      begin
        short_r <= cfg_wdata[`SBAP_CTL_SHORT];
        test_r <= cfg_wdata[`SBAP_CTL_TEST];
      end
      err_r <= (err_r & ~err_clr) | err_set; // R10
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else
      rdata_r <= rd_mux;
  end

  sbap_bit_engine #(
    .CW(CW),
    .QTR_NORM(QTR_NORM),
    .QTR_TEST(QTR_TEST)
  ) u_eng (
    .clock(clock),
    .rst_n(rst_n),
    .bus(bif.eng),
    .scl_oe(scl_oe),
    .sda_oe(sda_oe)
  );

  assign cfg_rdata = rdata_r;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
endmodule

/* bench/sbap_target_model.sv */
// Behavioural two-wire target that acknowledges its address, logs bytes and answers reads
`timescale 1ns/1ps
module sbap_target_model #(
  parameter logic [6:0] ADDR = 7'h50
) (
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe
);
  logic [7:0] sh;
  logic [7:0] idx;
  logic [7:0] log_q[$];
  logic [7:0] rb;
  int cnt;
  logic first, rd, sel, active;
  // Read answer depends on the last index written, so a wrong index shows
  assign rb = idx ^ 8'hc3;
  initial
  begin
    sda_oe = 1'b0;
    active = 1'b0;
    idx = 8'h00;
  end
  // Start or repeated start: next byte is an address
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      if (!active)
        log_q.delete();
      active = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      cnt = 0;
      sda_oe = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
    begin
      active = 1'b0;
      sda_oe = 1'b0;
    end
  always @(posedge scl)
    if (active)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      cnt = (cnt == 8) ? 0 : cnt + 1;
    end
  // Released line reads high through the pull-up
  always @(negedge scl)
    if (active)
    begin
      sda_oe = 1'b0;
      if (cnt == 8 && first)
      begin
        log_q.push_back(sh);
        first = 1'b0;
        sel = (sh[7:1] == ADDR);
        rd = sh[0];
        sda_oe = sel;
      end
      else if (cnt == 8 && !rd && sel)
      begin
        if (log_q.size() == 1)
          idx = sh;
        log_q.push_back(sh);
        sda_oe = 1'b1;
      end
      else if (cnt == 8)
        rd = 1'b0;
      else if (rd && sel)
        sda_oe = ~rb[7 - cnt];
    end
endmodule

/* bench/sbap_top_properties.sv */
// Port-level assertions for the serial byte access port
`timescale 1ns/1ps
module sbap_top_properties #(
  parameter int QTR_NORM = 4
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  localparam int IDLE = 10 * QTR_NORM;
  localparam int START_MAX = 3 * QTR_NORM;
  logic [15:0] idle_r;
  logic [15:0] idle_nxt;
  // Long quiet on both pins means no access is running
  assign idle_nxt = (scl_oe || sda_oe) ? 16'h0000 : idle_r + {15'h0000, idle_r != 16'hffff};
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      idle_r <= 16'h0000;
    else
      idle_r <= idle_nxt;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence idle_wr(logic [7:0] a);
    cfg_wr && cfg_addr == a && idle_r >= IDLE;
  endsequence
  sequence then_read(logic [7:0] a);
    ##1 cfg_addr == a;
  endsequence
  data_write_a: assert property (idle_wr(8'hb0) ##0 then_read(8'hb0) |=>
    cfg_rdata == $past(cfg_wdata, 2)) else $error("data readback differs");
  index_write_a: assert property (idle_wr(8'hb1) ##0 then_read(8'hb1) |=>
    cfg_rdata == $past(cfg_wdata, 2)) else $error("index readback differs");
  target_write_a: assert property (idle_wr(8'hb2) ##0 then_read(8'hb2) |=>
    cfg_rdata == $past(cfg_wdata, 2)) else $error("target readback differs");
  busy_flag_a: assert property (idle_wr(8'hb2) ##0 then_read(8'hb3) |=>
    cfg_rdata[5]) else $error("busy not set by request");
  start_cond_a: assert property (idle_wr(8'hb2) |-> ##[1:START_MAX] (sda_oe && !scl_oe))
    else $error("no start after request");
  err_clear_a: assert property (idle_wr(8'hb3) ##0 cfg_wdata[1] ##0 then_read(8'hb3) |=>
    !cfg_rdata[1]) else $error("error flag not cleared");
  unmapped_zero_a: assert property (($past(cfg_addr) < 8'hb0 || $past(cfg_addr) > 8'hb3)
    |-> cfg_rdata == 8'h00) else $error("unmapped read not zero");
  ctrl_reserved_a: assert property ($past(cfg_addr) == 8'hb3 |-> (cfg_rdata & 8'h59) == 8'h00)
    else $error("reserved control bits set");
  open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
    else $error("pin output level not low");
  reset_quiet_a: assert property (disable iff (1'b0) !rst_b |->
    cfg_rdata == 8'h00 && !scl_oe && !sda_oe) else $error("outputs active in reset");
endmodule
bind sbap_top sbap_top_properties #(.QTR_NORM(QTR_NORM)) chk_i (.clock(clock), .rst_b(rst_b),
  .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe));

/* bench/test_serial_bus_byte_access_port.sv */
// Self-checking bench for the serial byte access port
`timescale 1ns/1ps
module test_serial_bus_byte_access_port;
  localparam logic [6:0] TGT = 7'h50;
  logic clock, rst_b, cfg_wr, scl_out, scl_oe, sda_out, sda_oe, t_sda_oe;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, v;
  wire scl_w = ~scl_oe;
  wire sda_w = ~(sda_oe | t_sda_oe);
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;
  int t_norm, t_fast;
  sbap_top #(.QTR_NORM(4), .QTR_TEST(2)) DUT (.clock(clock), .rst_b(rst_b), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe));
  sbap_target_model #(.ADDR(TGT)) partner (.scl(scl_w), .sda(sda_w), .sda_oe(t_sda_oe));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      complete_run();
    end
  end
  task complete_run();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Strobe stays up across back-to-back writes; a read lowers it
  task wr(input logic [7:0] a, input logic [7:0] d);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    cfg_wr <= 1'b0;
    cfg_addr <= a;
    @(posedge clock);
    @(negedge clock);
    d = cfg_rdata;
    @(posedge clock);
  endtask
  task wait_done(output int n);
    logic [7:0] s;
    n = 0;
    s = 8'h20;
    while (s[5] === 1'b1 && n < 3000)
    begin
      rd(8'hb3, s);
      n++;
    end
    chk("busy", {7'h00, s[5]}, 8'h00);
    // Quiet bus before the next request, so that the port checks see it as idle
    repeat (50) @(posedge clock);
  endtask
  task chk_log(input int n, input logic [7:0] e [3]);
    chk("byte count", 8'(partner.log_q.size()), 8'(n));
    for (int i = 0; i < n; i++)
      chk("logged byte", partner.log_q[i], e[i]);
  endtask
  task reset_dut();
    rst_b <= 1'b0;
    cfg_wr <= 1'b0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (48) @(posedge clock);
  endtask
  initial
  begin
    // Starts high so that the reset below arrives as a falling edge
    rst_b = 1'b1;
    cfg_wr = 1'b0;
    cfg_addr = 8'h00;
    cfg_wdata = 8'h00;
    reset_dut();
    wr(8'hb4, 8'hff);
    for (int i = 0; i < 5; i++)
    begin
      rd(8'hb0 + 8'(i), v);
      chk("reset value", v, 8'h00);
    end
    $display("test reset done");
    wr(8'hb0, 8'ha5);
    rd(8'hb0, v);
    chk("data", v, 8'ha5);
    wr(8'hb1, 8'h3c);
    rd(8'hb1, v);
    chk("index", v, 8'h3c);
    $display("test readback done");
    wr(8'hb0, 8'h5a);
    wr(8'hb1, 8'h12);
    wr(8'hb2, {TGT, 1'b0});
    wr(8'hb1, 8'hff);
    wait_done(t_norm);
    rd(8'hb1, v);
    chk("index kept", v, 8'h12);
    chk_log(3, '{{TGT, 1'b0}, 8'h12, 8'h5a});
    $display("test indexed write done");
    wr(8'hb1, 8'h21);
    wr(8'hb2, {TGT, 1'b1});
    rd(8'hb3, v);
    chk("busy set", v & 8'h20, 8'h20);
    wait_done(t_fast);
    rd(8'hb0, v);
    chk("read data", v, 8'h21 ^ 8'hc3);
    chk_log(3, '{{TGT, 1'b0}, 8'h21, {TGT, 1'b1}});
    $display("test indexed read done");
    wr(8'hb3, 8'h80);
    wr(8'hb0, 8'h77);
    wr(8'hb2, {TGT, 1'b0});
    wait_done(t_fast);
    chk_log(2, '{{TGT, 1'b0}, 8'h77, 8'h00});
    wr(8'hb2, {TGT, 1'b1});
    wait_done(t_fast);
    rd(8'hb0, v);
    chk("short read", v, 8'h77 ^ 8'hc3);
    chk_log(1, '{{TGT, 1'b1}, 8'h00, 8'h00});
    $display("test short protocol done");
    wr(8'hb3, 8'h00);
    wr(8'hb2, {TGT ^ 7'h01, 1'b0});
    rd(8'hb2, v);
    chk("target", v, {TGT ^ 7'h01, 1'b0});
    wait_done(t_fast);
    rd(8'hb3, v);
    chk("error set", v, 8'h02);
    wr(8'hb3, 8'h02);
    rd(8'hb3, v);
    chk("error clear", v, 8'h00);
    $display("test missing acknowledge done");
    wr(8'hb1, 8'h12);
    wr(8'hb3, 8'h04);
    wr(8'hb2, {TGT, 1'b0});
    wait_done(t_fast);
    chk("fast shorter", {7'h00, t_fast < t_norm}, 8'h01);
    $display("test fast clock done");
    reset_dut();
    for (int i = 0; i < 3; i++)
    begin
      rd(8'hb0 + 8'(i), v);
      chk("cleared", v, 8'h00);
    end
    $display("test global reset done");
    complete_run();
  end
endmodule
